// [inc/stm_pkg.sv]
// Shared types and constants of the switch tag, mirror and rate block
package stm_pkg;
	// Clocking and rate arithmetic
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned UNITS_PER_BIT = CLK_HZ / 1000;
	localparam int unsigned UNITS_PER_BYTE = 8 * UNITS_PER_BIT;
	localparam int unsigned KBPS_STEP = 64;
	localparam int unsigned MBPS_KBPS = 1000;
	localparam int unsigned FINE_LAST_CODE = 15;
	localparam int unsigned COARSE_LAST_CODE = 115;
	localparam int unsigned SLOW_LINK_KBPS = 10_000;
	localparam int unsigned IFG_BYTES = 12;
	localparam int unsigned PREAMBLE_BYTES = 8;
	localparam int unsigned BURST_BYTES = 2000;
	localparam logic signed [31:0] BKT_CAP = 32'(BURST_BYTES * UNITS_PER_BYTE);
	localparam int unsigned NUM_BKT = 24;
	localparam int unsigned BKT_PER_DIR = 12;

	// Register addresses
	localparam logic [7:0] ADDR_GLOBAL_CTRL = 8'h03;
	localparam logic [7:0] ADDR_MIRROR_MODE = 8'h05;
	localparam logic [7:0] ADDR_P1_MIRROR = 8'h11;
	localparam logic [7:0] ADDR_P2_MIRROR = 8'h21;
	localparam logic [7:0] ADDR_P3_MIRROR = 8'h31;
	localparam logic [7:0] ADDR_RATE_OPT = 8'h5C;
	localparam logic [7:0] ADDR_STATUS = 8'h5D;
	localparam logic [2:0] ADDR_RATE_HI = 3'h3;

	// Field positions
	localparam int unsigned TAG_EN_BIT = 6;
	localparam int unsigned MIR_AND_BIT = 0;
	localparam int unsigned MIR_TX_BIT = 0;
	localparam int unsigned MIR_RX_BIT = 1;
	localparam int unsigned MIR_SNIFF_BIT = 2;
	localparam int unsigned OPT_ERR_BIT = 4;
	localparam int unsigned OPT_FC_BIT = 5;

	// Port codes and IGMP match fields
	localparam logic [1:0] PORT_1 = 2'h1;
	localparam logic [1:0] PORT_2 = 2'h2;
	localparam logic [1:0] PORT_3 = 2'h3;
	localparam logic [3:0] IP_V4 = 4'h4;
	localparam logic [7:0] IP_PROTO_IGMP = 8'h02;

	typedef enum logic [1:0] {DST_LOOKUP, DST_P1, DST_P2, DST_BOTH} stm_dst_t;
	typedef enum logic [1:0] {CLS_ALL, CLS_MCAST, CLS_BCAST, CLS_FLOOD} stm_cls_t;
	typedef enum logic [1:0] {SZ_DATA, SZ_IFG, SZ_PREAMBLE, SZ_RSVD} stm_size_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} stm_bus_t;

	// Frame descriptor from the receive MAC and lookup
	typedef struct packed {
		logic valid;
		logic [1:0] src;
		logic [2:0] lk_mask;
		logic [7:0] tag;
		logic eth_ip;
		logic snap_ip;
		logic [3:0] ip_ver;
		logic [7:0] ip_proto;
		logic errored;
		stm_cls_t cls;
		logic [1:0] prio;
		logic [10:0] len;
	} stm_frm_t;

	// Forwarding decision
	typedef struct packed {
		logic valid;
		logic [2:0] fwd;
		logic [1:0] prio;
		logic drop;
		logic strip_tag;
		logic add_tag;
		logic [7:0] tag;
		logic mirrored;
		logic igmp;
	} stm_dec_t;

	// Egress frame start from the scheduler
	typedef struct packed {
		logic valid;
		logic [1:0] port;
		logic [1:0] prio;
		logic [10:0] len;
	} stm_tx_t;
endpackage

// [verilog/stm_engine.sv]
// Forwarding engine: host tag, IGMP trap, mirroring, rate policing and shaping
//
// Operation
// - Tag only on port 3, when enabled
// - Tag low bits name port
// - Host tag bits 3:2 give priority
// - Host destination code selects ports
// - Host-bound tag bit 0 marks source port
// - Trap IGMP frames to port 3 only
// - IGMP is IPv4 protocol 2, Ethernet or SNAP encapsulation
// - Strip tag before network transmit
// - Receive-mirrored frames copied to sniffer
// - Optionally mirror errored frames too
// - Transmit-mirrored frames copied to sniffer
// - AND mode needs both mirror conditions
// - Any ports mirror, any port sniffs
// - Rates 64k steps, then 1M steps
// - Separate limits per direction, port, priority
// - Slow port above 10M means unlimited
// - Charge frame bytes, optional IFG/preamble
// - Ingress drops selected class over rate
// - Egress leaky bucket paces each queue
// - Full queue drops or pauses
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/100ps
module stm_engine (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire stm_pkg::stm_bus_t bus_i,
	output logic [7:0] rdata_o,
	input wire stm_pkg::stm_frm_t frm_i,
	output stm_pkg::stm_dec_t dec_o,
	input wire stm_pkg::stm_tx_t tx_i,
	input wire logic [2:0] speed_100_i,
	input wire logic [2:0] q_full_i,
	output logic [11:0] eg_ok_o,
	output logic [2:0] pause_o
);

	typedef struct packed {
		logic [7:0] gctrl;
		logic [7:0] mmode;
		logic [2:0][7:0] pmir;
		logic [7:0] ropt;
		logic [23:0][6:0] rcode;
		logic [23:0][31:0] bkt;
		stm_pkg::stm_dec_t dec;
		logic [2:0] pause;
		logic [7:0] rdata;
	} stm_state_t;

	stm_state_t s_q;
	stm_state_t s_d;

	////////////////////////////////////////////////////////////////////////////
	// Rate decode per bucket
	logic [23:0] unl;
	logic [23:0][16:0] kbps;

	genvar gi;
	generate
		for (gi = 0; gi < 24; gi++) begin : g_rate
			localparam int unsigned PIDX = (gi % 12) / 4;
			logic [6:0] code;
			logic [16:0] rk;
			assign code = s_q.rcode[gi];
			assign rk = (code <= 7'(stm_pkg::FINE_LAST_CODE)) ? 17'(code * stm_pkg::KBPS_STEP) :
				17'((code - 7'(stm_pkg::FINE_LAST_CODE)) * stm_pkg::MBPS_KBPS);
			assign kbps[gi] = rk;
			assign unl[gi] = (code == 7'h00) || (code > 7'(stm_pkg::COARSE_LAST_CODE)) ||
				(!speed_100_i[PIDX] && rk > 17'(stm_pkg::SLOW_LINK_KBPS));
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Frame charge in bucket units
	function automatic logic signed [31:0] charge(input logic [10:0] len, input logic [1:0] mode);
		logic [11:0] bytes;
		bytes = {1'b0, len};
		if (mode == stm_pkg::SZ_IFG)
			bytes = bytes + 12'(stm_pkg::IFG_BYTES);
		else if (mode == stm_pkg::SZ_PREAMBLE)
			bytes = bytes + 12'(stm_pkg::PREAMBLE_BYTES);
		return 32'(bytes * stm_pkg::UNITS_PER_BYTE);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Next state
	logic tag_en;
	logic and_mode;
	assign tag_en = s_q.gctrl[stm_pkg::TAG_EN_BIT];
	assign and_mode = s_q.mmode[stm_pkg::MIR_AND_BIT];

	always_comb begin
		logic [2:0] rxs;
		logic [2:0] txs;
		logic [2:0] snf;
		logic [2:0] fwd;
		logic [1:0] si;
		logic [1:0] prio;
		logic [4:0] ix;
		logic [4:0] ex;
		logic igmp;
		logic hosttag;
		logic mir;
		logic drop;
		logic cls_hit;
		logic signed [32:0] sum;
		rxs = '0;
		txs = '0;
		snf = '0;
		fwd = '0;
		si = '0;
		prio = '0;
		ix = '0;
		ex = '0;
		igmp = 1'b0;
		hosttag = 1'b0;
		mir = 1'b0;
		drop = 1'b0;
		cls_hit = 1'b0;
		sum = '0;
		s_d = s_q;
		s_d.dec.valid = 1'b0;
		s_d.rdata = 8'h00;

		// Register writes
		if (bus_i.wr) begin
			case (bus_i.addr)
				stm_pkg::ADDR_GLOBAL_CTRL: s_d.gctrl = bus_i.wdata;
				stm_pkg::ADDR_MIRROR_MODE: s_d.mmode = bus_i.wdata;
				stm_pkg::ADDR_P1_MIRROR: s_d.pmir[0] = bus_i.wdata;
				stm_pkg::ADDR_P2_MIRROR: s_d.pmir[1] = bus_i.wdata;
				stm_pkg::ADDR_P3_MIRROR: s_d.pmir[2] = bus_i.wdata;
				stm_pkg::ADDR_RATE_OPT: s_d.ropt = bus_i.wdata;
				default: begin
					if (bus_i.addr[7:5] == stm_pkg::ADDR_RATE_HI && bus_i.addr[3:2] != 2'b11)
						s_d.rcode[5'(bus_i.addr[4] * 12 + bus_i.addr[3:2] * 4 + bus_i.addr[1:0])] =
							bus_i.wdata[6:0];
				end
			endcase
		end

		// Register reads, data in the next cycle only
		if (bus_i.rd) begin
			case (bus_i.addr)
				stm_pkg::ADDR_GLOBAL_CTRL: s_d.rdata = s_q.gctrl;
				stm_pkg::ADDR_MIRROR_MODE: s_d.rdata = s_q.mmode;
				stm_pkg::ADDR_P1_MIRROR: s_d.rdata = s_q.pmir[0];
				stm_pkg::ADDR_P2_MIRROR: s_d.rdata = s_q.pmir[1];
				stm_pkg::ADDR_P3_MIRROR: s_d.rdata = s_q.pmir[2];
				stm_pkg::ADDR_RATE_OPT: s_d.rdata = s_q.ropt;
				stm_pkg::ADDR_STATUS: s_d.rdata = {s_q.pause, s_q.dec.igmp, s_q.dec.drop, s_q.dec.fwd};
				default: begin
					if (bus_i.addr[7:5] == stm_pkg::ADDR_RATE_HI && bus_i.addr[3:2] != 2'b11)
						s_d.rdata = {1'b0,
							s_q.rcode[5'(bus_i.addr[4] * 12 + bus_i.addr[3:2] * 4 + bus_i.addr[1:0])]};
				end
			endcase
		end

		for (int i = 0; i < 24; i++) begin
			sum = 33'($signed(s_q.bkt[i])) + 33'($signed({15'h0000, kbps[i]}));
			if (unl[i] || sum > 33'($signed(stm_pkg::BKT_CAP)))
				s_d.bkt[i] = stm_pkg::BKT_CAP;
			else
				s_d.bkt[i] = 32'(sum);
		end

		for (int p = 0; p < 3; p++) begin
			rxs[p] = s_q.pmir[p][stm_pkg::MIR_RX_BIT];
			txs[p] = s_q.pmir[p][stm_pkg::MIR_TX_BIT];
			snf[p] = s_q.pmir[p][stm_pkg::MIR_SNIFF_BIT];
		end

		// Frame decision
		if (frm_i.valid && frm_i.src != 2'b00) begin
			si = frm_i.src - 2'd1;
			fwd = frm_i.lk_mask;
			prio = frm_i.prio;
			// Host tag only on port 3
			hosttag = tag_en && frm_i.src == stm_pkg::PORT_3;
			if (hosttag) begin
				prio = frm_i.tag[3:2];
				case (stm_pkg::stm_dst_t'(frm_i.tag[1:0]))
					stm_pkg::DST_LOOKUP: fwd = frm_i.lk_mask;
					stm_pkg::DST_P1: fwd = 3'b001;
					stm_pkg::DST_P2: fwd = 3'b010;
					stm_pkg::DST_BOTH: fwd = 3'b011;
					default: fwd = frm_i.lk_mask;
				endcase
			end
			// IPv4 protocol 2 in either encapsulation
			igmp = (frm_i.eth_ip || frm_i.snap_ip) && frm_i.ip_ver == stm_pkg::IP_V4 &&
				frm_i.ip_proto == stm_pkg::IP_PROTO_IGMP && frm_i.src != stm_pkg::PORT_3;
			if (igmp)
				fwd = 3'b100;
			fwd[si] = 1'b0;
			// AND or OR combination of mirror sources
			if (and_mode)
				mir = rxs[si] && (fwd & txs) != 3'b000;
			else
				mir = rxs[si] || (fwd & txs) != 3'b000;
			// Errored frames reach sniffer only on option
			if (frm_i.errored) begin
				mir = rxs[si] && s_q.ropt[stm_pkg::OPT_ERR_BIT];
				fwd = 3'b000;
				drop = !mir;
			end
			ix = 5'(si * 4 + prio);
			cls_hit = s_q.ropt[3:2] == stm_pkg::CLS_ALL || s_q.ropt[3:2] == frm_i.cls;
			if (!drop && cls_hit && !unl[ix]) begin
				if ($signed(s_q.bkt[ix]) < 0) begin
					drop = 1'b1;
					mir = 1'b0;
				end else begin
					s_d.bkt[ix] = 32'($signed(s_d.bkt[ix]) - charge(frm_i.len, s_q.ropt[1:0]));
				end
			end
			if (!drop && (fwd & q_full_i) != 3'b000) begin
				if (s_q.ropt[stm_pkg::OPT_FC_BIT])
					s_d.pause[si] = 1'b1;
				else begin
					drop = 1'b1;
					mir = 1'b0;
				end
			end
			if (mir)
				fwd = fwd | (snf & ~(3'b001 << si));
			if (drop)
				fwd = 3'b000;
			s_d.dec.valid = 1'b1;
			s_d.dec.fwd = fwd;
			s_d.dec.prio = prio;
			s_d.dec.drop = drop;
			s_d.dec.strip_tag = hosttag;
			s_d.dec.add_tag = tag_en && fwd[2] && frm_i.src != stm_pkg::PORT_3;
			s_d.dec.tag = {7'h00, frm_i.src == stm_pkg::PORT_2};
			s_d.dec.mirrored = mir;
			s_d.dec.igmp = igmp;
		end

		if (q_full_i == 3'b000)
			s_d.pause = 3'b000;

		// Egress leaky bucket charge at frame start
		if (tx_i.valid && tx_i.port != 2'b00) begin
			ex = 5'(stm_pkg::BKT_PER_DIR + (tx_i.port - 2'd1) * 4 + tx_i.prio);
			if (!unl[ex])
				s_d.bkt[ex] = 32'($signed(s_d.bkt[ex]) - charge(tx_i.len, s_q.ropt[1:0]));
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
			for (int i = 0; i < 24; i++)
				s_q.bkt[i] <= stm_pkg::BKT_CAP;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign rdata_o = s_q.rdata;
	assign dec_o = s_q.dec;
	assign pause_o = s_q.pause;
	for (gi = 0; gi < 12; gi++) begin : g_ok
		assign eg_ok_o[gi] = !s_q.bkt[stm_pkg::BKT_PER_DIR + gi][31];
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence s_host_frm;
		frm_i.valid && frm_i.src == stm_pkg::PORT_3 && tag_en;
	endsequence

	sequence s_net_frm;
		frm_i.valid && (frm_i.src == stm_pkg::PORT_1 || frm_i.src == stm_pkg::PORT_2);
	endsequence

	property p_tag_port3;
		@(posedge clock_i) disable iff (sys_rst_i)
		dec_o.valid && dec_o.add_tag |-> dec_o.fwd[2] && $past(tag_en);
	endproperty
	a_tag_port3: assert property (p_tag_port3) else $error("tag added off host port");

	property p_src_bit;
		@(posedge clock_i) disable iff (sys_rst_i)
		s_net_frm |=> dec_o.tag[0] == ($past(frm_i.src) == stm_pkg::PORT_2) && dec_o.tag[7:1] == 7'h00;
	endproperty
	a_src_bit: assert property (p_src_bit) else $error("source bit wrong");

	property p_host_prio;
		@(posedge clock_i) disable iff (sys_rst_i)
		s_host_frm |=> dec_o.valid && dec_o.prio == $past(frm_i.tag[3:2]) && dec_o.strip_tag;
	endproperty
	a_host_prio: assert property (p_host_prio) else $error("host priority or strip wrong");

	property p_host_p1;
		@(posedge clock_i) disable iff (sys_rst_i)
		s_host_frm ##0 (frm_i.tag[1:0] == 2'b01 && !frm_i.errored) |=> dec_o.drop || dec_o.fwd[0];
	endproperty
	a_host_p1: assert property (p_host_p1) else $error("destination decode wrong");

	property p_igmp_trap;
		@(posedge clock_i) disable iff (sys_rst_i)
		s_net_frm ##0 (frm_i.ip_ver == stm_pkg::IP_V4 && frm_i.ip_proto == stm_pkg::IP_PROTO_IGMP &&
			frm_i.eth_ip && !frm_i.errored) |=> dec_o.igmp && (dec_o.drop || dec_o.fwd[2]);
	endproperty
	a_igmp_trap: assert property (p_igmp_trap) else $error("IGMP not trapped");

	property p_no_strip_net;
		@(posedge clock_i) disable iff (sys_rst_i)
		s_net_frm |=> !dec_o.strip_tag && !dec_o.fwd[$past(frm_i.src) - 2'd1];
	endproperty
	a_no_strip_net: assert property (p_no_strip_net) else $error("bad strip or reflection");

	property p_mirror_sniff;
		@(posedge clock_i) disable iff (sys_rst_i)
		dec_o.valid && dec_o.drop |-> dec_o.fwd == 3'b000 && !dec_o.mirrored;
	endproperty
	a_mirror_sniff: assert property (p_mirror_sniff) else $error("dropped frame forwarded");

	property p_and_mode;
		@(posedge clock_i) disable iff (sys_rst_i)
		s_net_frm ##0 (and_mode && !rxs_of_src()) |=> !dec_o.mirrored;
	endproperty
	a_and_mode: assert property (p_and_mode) else $error("AND mirror ignored");

	function automatic logic rxs_of_src();
		return s_q.pmir[frm_i.src - 2'd1][stm_pkg::MIR_RX_BIT];
	endfunction

	property p_police;
		@(posedge clock_i) disable iff (sys_rst_i)
		s_net_frm ##0 (!frm_i.errored && s_q.ropt[3:2] == stm_pkg::CLS_ALL &&
			!unl[5'((frm_i.src - 2'd1) * 4 + frm_i.prio)] &&
			s_q.bkt[5'((frm_i.src - 2'd1) * 4 + frm_i.prio)][31]) |=> dec_o.drop;
	endproperty
	a_police: assert property (p_police) else $error("over-rate frame passed");

	property p_unlimited;
		@(posedge clock_i) disable iff (sys_rst_i)
		unl[0] && !(frm_i.valid) ##1 unl[0] |-> s_q.bkt[0] == stm_pkg::BKT_CAP;
	endproperty
	a_unlimited: assert property (p_unlimited) else $error("unlimited bucket not full");
endmodule

// [testbench/stm_host_model.sv]
// Host processor model on the third switch port
`timescale 1ns/100ps
module stm_host_model (
	input wire logic clock_i,
	input wire stm_pkg::stm_dec_t dec_i,
	output stm_pkg::stm_frm_t frm_o
);
	always @(posedge clock_i) begin
		stm_pkg::stm_frm_t f;
		f = '0;
		if (dec_i.valid === 1'b1 && dec_i.igmp === 1'b1 && dec_i.add_tag === 1'b1) begin
			f.valid = 1'b1;
			f.src = stm_pkg::PORT_3;
			f.len = 11'h040;
			f.tag = {4'h0, 2'h2, dec_i.tag[0] ? 2'h2 : 2'h1};
		end
		frm_o <= f;
	end
endmodule

// [testbench/stm_engine_tb.sv]
// Self-checking bench of the switch forwarding engine
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin failures++; $display("FAIL %s exp %h got %h", n, e, a); end end
module stm_engine_tb;
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	stm_pkg::stm_bus_t bus = '0;
	stm_pkg::stm_frm_t bf = '0;
	stm_pkg::stm_frm_t hf;
	stm_pkg::stm_frm_t fi;
	stm_pkg::stm_tx_t tx = '0;
	logic [2:0] spd = 3'h7;
	logic [2:0] qf = 3'h0;
	logic [7:0] rdata;
	stm_pkg::stm_dec_t dec;
	logic [11:0] eg_ok;
	logic [2:0] pause;
	int failures = 0;
	int checks_done = 0;
	assign fi = (hf.valid === 1'b1) ? hf : bf;
	stm_engine i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus_i(bus), .rdata_o(rdata), .frm_i(fi),
		.dec_o(dec), .tx_i(tx), .speed_100_i(spd), .q_full_i(qf), .eg_ok_o(eg_ok), .pause_o(pause));
	stm_host_model i_host (.clock_i(clock_i), .dec_i(dec), .frm_o(hf));
	initial forever #25 clock_i = ~clock_i;
	////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic rst();
		sys_rst_i <= 1'b1;
		repeat (8) @(posedge clock_i);
		sys_rst_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		bus <= '{1'b1, 1'b0, a, d};
		@(posedge clock_i);
		bus <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock_i);
		bus <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clock_i);
		bus <= '0;
		#1 `CHK("rdata", e, rdata)
	endtask
	function automatic stm_pkg::stm_frm_t mk(logic [1:0] s, logic [2:0] m, logic [10:0] l);
		mk = '0;
		mk.valid = 1'b1;
		mk.src = s;
		mk.lk_mask = m;
		mk.len = l;
	endfunction
	task automatic send(input stm_pkg::stm_frm_t f);
		@(posedge clock_i);
		bf <= f;
		@(posedge clock_i);
		bf.valid <= 1'b0;
		#1;
	endtask
	task automatic dchk(input logic [2:0] e);
		`CHK("dec valid", 1'b1, dec.valid)
		`CHK("fwd", e, dec.fwd)
		`CHK("drop", e == 3'h0, dec.drop)
	endtask
	task automatic fr(input logic [1:0] s, input logic [2:0] m, input logic [2:0] e);
		send(mk(s, m, 11'h040));
		dchk(e);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rst();
		rd(stm_pkg::ADDR_GLOBAL_CTRL, 8'h00);
		rd(stm_pkg::ADDR_MIRROR_MODE, 8'h00);
		rd(stm_pkg::ADDR_P3_MIRROR, 8'h00);
		wr(8'h40, 8'hFF);
		rd(8'h40, 8'h00);
		wr(stm_pkg::ADDR_STATUS, 8'hFF);
		rd(stm_pkg::ADDR_STATUS, 8'h00);
		wr(stm_pkg::ADDR_GLOBAL_CTRL, 8'h40);
		rd(stm_pkg::ADDR_GLOBAL_CTRL, 8'h40);
		$display("test regs done");
	endtask
	task automatic t_tag();
		stm_pkg::stm_frm_t f;
		rst();
		f = mk(stm_pkg::PORT_3, 3'h2, 11'h040);
		f.tag = 8'h05;
		send(f);
		dchk(3'h2);
		`CHK("strip", 1'b0, dec.strip_tag)
		wr(stm_pkg::ADDR_GLOBAL_CTRL, 8'h40);
		for (int i = 0; i < 16; i++) begin
			f.tag = 8'(i);
			f.lk_mask = (i % 4 == 2) ? 3'h1 : 3'h2;
			send(f);
			dchk((i % 4 == 0) ? 3'h2 : {1'b0, 2'(i)});
			`CHK("prio", 2'(i >> 2), dec.prio)
			`CHK("strip", 1'b1, dec.strip_tag)
		end
		f = mk(stm_pkg::PORT_2, 3'h4, 11'h040);
		send(f);
		`CHK("add", 1'b1, dec.add_tag)
		`CHK("src bit", 1'b1, dec.tag[0])
		f.src = stm_pkg::PORT_1;
		send(f);
		`CHK("src bit", 1'b0, dec.tag[0])
		f.lk_mask = 3'h2;
		send(f);
		`CHK("add", 1'b0, dec.add_tag)
		$display("test tag done");
	endtask
	task automatic igmp(input logic [1:0] s, input logic sn, input logic [3:0] v, input logic [7:0] p,
		input logic [2:0] e);
		stm_pkg::stm_frm_t f;
		f = mk(s, (s == stm_pkg::PORT_1) ? 3'h2 : 3'h1, 11'h040);
		f.eth_ip = ~sn;
		f.snap_ip = sn;
		f.ip_ver = v;
		f.ip_proto = p;
		send(f);
		dchk(e);
		if (e == 3'h4) begin
			`CHK("igmp", 1'b1, dec.igmp)
			repeat (2) @(posedge clock_i);
			#1 dchk((s == stm_pkg::PORT_1) ? 3'h1 : 3'h2);
			`CHK("prio", 2'h2, dec.prio)
		end
	endtask
	task automatic t_igmp();
		rst();
		wr(stm_pkg::ADDR_GLOBAL_CTRL, 8'h40);
		igmp(stm_pkg::PORT_2, 1'b0, 4'h4, 8'h02, 3'h4);
		igmp(stm_pkg::PORT_1, 1'b1, 4'h4, 8'h02, 3'h4);
		igmp(stm_pkg::PORT_1, 1'b0, 4'h6, 8'h02, 3'h2);
		igmp(stm_pkg::PORT_1, 1'b0, 4'h4, 8'h11, 3'h2);
		$display("test igmp done");
	endtask
	task automatic t_mirror();
		stm_pkg::stm_frm_t f;
		rst();
		wr(stm_pkg::ADDR_P1_MIRROR, 8'h02);
		wr(stm_pkg::ADDR_P3_MIRROR, 8'h04);
		fr(stm_pkg::PORT_1, 3'h2, 3'h6);
		`CHK("mirrored", 1'b1, dec.mirrored)
		fr(stm_pkg::PORT_2, 3'h1, 3'h1);
		`CHK("mirrored", 1'b0, dec.mirrored)
		wr(stm_pkg::ADDR_P1_MIRROR, 8'h01);
		fr(stm_pkg::PORT_2, 3'h1, 3'h5);
		fr(stm_pkg::PORT_1, 3'h2, 3'h2);
		wr(stm_pkg::ADDR_P1_MIRROR, 8'h02);
		f = mk(stm_pkg::PORT_1, 3'h2, 11'h040);
		f.errored = 1'b1;
		send(f);
		dchk(3'h0);
		wr(stm_pkg::ADDR_RATE_OPT, 8'h10);
		send(f);
		dchk(3'h4);
		wr(stm_pkg::ADDR_MIRROR_MODE, 8'h01);
		wr(stm_pkg::ADDR_P2_MIRROR, 8'h01);
		fr(stm_pkg::PORT_1, 3'h2, 3'h6);
		wr(stm_pkg::ADDR_P2_MIRROR, 8'h00);
		fr(stm_pkg::PORT_1, 3'h2, 3'h2);
		$display("test mirror done");
	endtask
	task automatic t_rate();
		stm_pkg::stm_frm_t f;
		rst();
		wr(8'h60, 8'h01);
		f = mk(stm_pkg::PORT_1, 3'h2, 11'h5DC);
		for (int i = 0; i < 3; i++) begin
			send(f);
			dchk((i == 2) ? 3'h0 : 3'h2);
		end
		f.prio = 2'h1;
		send(f);
		dchk(3'h2);
		wr(8'h70, 8'h01);
		for (int i = 0; i < 2; i++) begin
			@(posedge clock_i);
			tx <= '{1'b1, stm_pkg::PORT_1, 2'h0, 11'h5DC};
			@(posedge clock_i);
			tx.valid <= 1'b0;
			@(posedge clock_i);
			#1 `CHK("eg ok", i == 0, eg_ok[0])
		end
		`CHK("eg other", 1'b1, eg_ok[1])
		rst();
		spd <= 3'h5;
		wr(8'h64, 8'h1A);
		wr(8'h60, 8'h1A);
		for (int i = 0; i < 3; i++) begin
			f = mk(stm_pkg::PORT_2, 3'h1, 11'h5DC);
			send(f);
			dchk(3'h1);
			f = mk(stm_pkg::PORT_1, 3'h2, 11'h5DC);
			send(f);
			dchk((i == 2) ? 3'h0 : 3'h2);
		end
		spd <= 3'h7;
		rst();
		wr(stm_pkg::ADDR_RATE_OPT, 8'h09);
		wr(8'h60, 8'h01);
		f = mk(stm_pkg::PORT_1, 3'h2, 11'h7C5);
		f.cls = stm_pkg::CLS_MCAST;
		for (int i = 0; i < 3; i++) begin
			send(f);
			dchk(3'h2);
		end
		f.cls = stm_pkg::CLS_BCAST;
		for (int i = 0; i < 2; i++) begin
			send(f);
			dchk((i == 1) ? 3'h0 : 3'h2);
		end
		$display("test rate done");
	endtask
	task automatic t_flow();
		rst();
		qf <= 3'h2;
		fr(stm_pkg::PORT_1, 3'h2, 3'h0);
		wr(stm_pkg::ADDR_RATE_OPT, 8'h20);
		send(mk(stm_pkg::PORT_1, 3'h2, 11'h040));
		@(posedge clock_i);
		#1 `CHK("pause", 3'h1, pause)
		@(posedge clock_i);
		qf <= 3'h0;
		repeat (2) @(posedge clock_i);
		#1 `CHK("pause", 3'h0, pause)
		$display("test flow done");
	endtask
	initial begin
		#2000000;
		failures++;
		close_out();
	end
	initial begin
		t_regs();
		t_tag();
		t_igmp();
		t_mirror();
		t_rate();
		t_flow();
		close_out();
	end
endmodule
